//--- rtl/gpf_pkg.sv
// package: register map, reset values and field positions of the pin flag block
package gpf_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_P0_FLAGS = 8'h89;
   localparam logic [7:0] IDX_P1_FLAGS = 8'h8A;
   localparam logic [7:0] IDX_P2_FLAGS = 8'h8B;
   localparam logic [7:0] IDX_P1_COND  = 8'hF6;
   localparam logic [7:0] IDX_P2_COND  = 8'hF7;
   localparam logic [7:0] IDX_P0_MASK  = 8'h90;
   localparam logic [7:0] IDX_P1_MASK  = 8'h91;
   localparam logic [7:0] IDX_P2_MASK  = 8'h92;
   localparam logic [7:0] IDX_EDGE_SEL = 8'h93;
   // widths of the three ports
   localparam int P0_PINS = 8;
   localparam int P1_PINS = 8;
   localparam int P2_PINS = 5;
   // field positions
   localparam int P1_FLOAT_LO     = 2;  // lowest port 1 pin with a pull
   localparam int P2_PULL_DIR_BIT = 7;
   localparam int P1_PULL_DIR_BIT = 6;
   localparam int P0_PULL_DIR_BIT = 5;
   localparam int P0_RESUME_BIT   = 7;
   localparam int P0_UNUSED_BIT   = 6;
   localparam int EDGE_P0_BIT     = 0;
   localparam int EDGE_P1_BIT     = 1;
   localparam int EDGE_P2_BIT     = 2;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_P2   = 5'h00;
   localparam logic [2:0] RST_EDGE = 3'h0;
endpackage : gpf_pkg

//--- rtl/gpf_edge_if.sv
// interface: pin levels in, edge choice in, edge events out
interface gpf_edge_if #(parameter int W = 8);
   logic [W-1:0] pin;      // sampled pin levels
   logic         falling;  // 1 picks falling edges
   logic [W-1:0] event_p;  // one-cycle edge pulses
   modport ctl (output pin, output falling, input event_p);
   modport det (input pin, input falling, output event_p);
endinterface : gpf_edge_if

//--- rtl/gpf_edge.sv
// module: per-pin edge detector for one port
module gpf_edge #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // port side
   gpf_edge_if.det  port
);
   logic [W-1:0] prev_r;   // last pin levels
   logic [W-1:0] prev_nxt;
   logic         armed_r;  // prev_r holds a real sample
   logic         armed_nxt;

   // next values: no edge until one true sample is held
   always_comb begin
      prev_nxt  = port.pin;
      armed_nxt = 1'b1;
      if (!armed_r) begin
         port.event_p = '0;
      end else if (port.falling) begin
         port.event_p = prev_r & ~port.pin;
      end else begin
         port.event_p = ~prev_r & port.pin;
      end
   end

   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r  <= '0;
         armed_r <= 1'b0;
      end else begin
         prev_r  <= prev_nxt;
         armed_r <= armed_nxt;
      end
   end
endmodule : gpf_edge

//--- rtl/gpf_top.sv
// module: gpio input conditioning and pin pending flags with apb access
//
// Local design decision: the APB interface to the registers.
module gpf_top #(
   parameter bit HAS_BUS_RESUME = 1'b0  // variant with bus resume flag
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // pin levels, synchronous to pclk
   input  wire logic [7:0]  p0_in,
   input  wire logic [7:0]  p1_in,
   input  wire logic [4:0]  p2_in,
   // port 0 float selects from the neighbouring block
   input  wire logic [7:0]  p0_float_sel,
   // bus resume pulse, used on the resume variant only
   input  wire logic        bus_resume_evt,
   // pad pull controls
   output logic [7:0]       p0_pull_up,
   output logic [7:0]       p0_pull_down,
   output logic [7:0]       p1_pull_up,
   output logic [7:0]       p1_pull_down,
   output logic [4:0]       p2_pull_up,
   output logic [4:0]       p2_pull_down,
   // interrupt
   output logic             irq
);
   // pulled pins get up or down, floating pins get neither
   function automatic logic [7:0] pull_on(input logic [7:0] flt, input logic dir_down,
                                          input logic want_down);
      pull_on = (dir_down == want_down) ? ~flt : 8'h00;
   endfunction : pull_on

   // a mapped index is one of the nine registers
   function automatic logic is_mapped(input logic [11:0] a);
      logic [7:0] i;
      i = a[9:2];
      is_mapped = (a[11:10] == 2'b00) && (a[1:0] == 2'b00) &&
                  (i == gpf_pkg::IDX_P0_FLAGS || i == gpf_pkg::IDX_P1_FLAGS ||
                   i == gpf_pkg::IDX_P2_FLAGS || i == gpf_pkg::IDX_P1_COND  ||
                   i == gpf_pkg::IDX_P2_COND  || i == gpf_pkg::IDX_P0_MASK  ||
                   i == gpf_pkg::IDX_P1_MASK  || i == gpf_pkg::IDX_P2_MASK  ||
                   i == gpf_pkg::IDX_EDGE_SEL);
   endfunction : is_mapped

   // control registers
   logic [7:0] p1_cond_r;    // float selects and zeros below
   logic [7:0] p1_cond_nxt;
   logic [7:0] p2_cond_r;    // pull directions and port 2 floats
   logic [7:0] p2_cond_nxt;
   logic [2:0] edge_r;       // per-port falling select
   logic [2:0] edge_nxt;
   logic [7:0] mask0_r;      // interrupt masks, 1 passes
   logic [7:0] mask0_nxt;
   logic [7:0] mask1_r;
   logic [7:0] mask1_nxt;
   logic [4:0] mask2_r;
   logic [4:0] mask2_nxt;
   // pending flags
   logic [7:0] p0f_r;
   logic [7:0] p0f_nxt;
   logic [7:0] p1f_r;
   logic [7:0] p1f_nxt;
   logic [4:0] p2f_r;
   logic [4:0] p2f_nxt;
   // bus answer
   logic [7:0] rd_r;
   logic [7:0] rd_nxt;
   logic       err_r;
   logic       err_nxt;
   // pads
   logic [7:0] p0_pu_nxt;
   logic [7:0] p0_pd_nxt;
   logic [7:0] p1_pu_nxt;
   logic [7:0] p1_pd_nxt;
   logic [4:0] p2_pu_nxt;
   logic [4:0] p2_pd_nxt;
   logic       irq_nxt;
   // decode
   logic [7:0] idx;          // word index of the address
   logic       wr_acc;       // write taking effect this edge
   logic [7:0] wbyte;        // low byte of write data
   logic [7:0] set0;         // port 0 flag set terms
   logic [7:0] ev0;          // edge events per port
   logic [7:0] ev1;
   logic [4:0] ev2;

   // edge detectors, one per port
   gpf_edge_if #(.W(8)) e0_if ();
   gpf_edge_if #(.W(8)) e1_if ();
   gpf_edge_if #(.W(5)) e2_if ();

   assign e0_if.pin     = p0_in;
   assign e1_if.pin     = p1_in;
   assign e2_if.pin     = p2_in;
   assign e0_if.falling = edge_r[gpf_pkg::EDGE_P0_BIT];
   assign e1_if.falling = edge_r[gpf_pkg::EDGE_P1_BIT];
   assign e2_if.falling = edge_r[gpf_pkg::EDGE_P2_BIT];
   assign ev0           = e0_if.event_p;
   assign ev1           = e1_if.event_p;
   assign ev2           = e2_if.event_p;

   gpf_edge #(.W(8)) u_e0 (.pclk(pclk), .presetn(presetn), .port(e0_if.det));
   gpf_edge #(.W(8)) u_e1 (.pclk(pclk), .presetn(presetn), .port(e1_if.det));
   gpf_edge #(.W(5)) u_e2 (.pclk(pclk), .presetn(presetn), .port(e2_if.det));

   // apb always answers in one access cycle
   assign pready = 1'b1;
   assign prdata = {24'h00_0000, rd_r};
   assign pslverr = err_r;
   assign idx    = paddr[9:2];
   assign wbyte  = pwdata[7:0];
   // only the low byte lane holds data; a write without it is dropped
   assign wr_acc = psel && penable && pwrite && pstrb[0] && is_mapped(paddr);

   // port 0 set terms: resume variant repurposes the top two bits
   always_comb begin
      set0 = ev0;
      if (HAS_BUS_RESUME) begin
         set0[gpf_pkg::P0_RESUME_BIT] = bus_resume_evt;
         set0[gpf_pkg::P0_UNUSED_BIT] = 1'b0;
      end
   end

   // next values of control registers
   always_comb begin
      p1_cond_nxt = p1_cond_r;
      p2_cond_nxt = p2_cond_r;
      edge_nxt    = edge_r;
      mask0_nxt   = mask0_r;
      mask1_nxt   = mask1_r;
      mask2_nxt   = mask2_r;
      if (wr_acc) begin
         case (idx)
            gpf_pkg::IDX_P1_COND: begin
               p1_cond_nxt = {wbyte[7:2], 2'b00};
            end
            gpf_pkg::IDX_P2_COND: begin
               p2_cond_nxt = wbyte;
            end
            gpf_pkg::IDX_EDGE_SEL: begin
               edge_nxt = wbyte[2:0];
            end
            gpf_pkg::IDX_P0_MASK: begin
               mask0_nxt = wbyte;
            end
            gpf_pkg::IDX_P1_MASK: begin
               mask1_nxt = wbyte;
            end
            gpf_pkg::IDX_P2_MASK: begin
               mask2_nxt = wbyte[4:0];
            end
            default: begin
               // flag registers handled below
            end
         endcase
      end
   end

   // next flags: a set in the clearing cycle wins over the clear
   always_comb begin
      p0f_nxt = p0f_r | set0;
      p1f_nxt = p1f_r | ev1;
      p2f_nxt = p2f_r | ev2;
      if (wr_acc && idx == gpf_pkg::IDX_P0_FLAGS) begin
         p0f_nxt = (p0f_r & wbyte) | set0;
      end
      if (wr_acc && idx == gpf_pkg::IDX_P1_FLAGS) begin
         p1f_nxt = (p1f_r & wbyte) | ev1;
      end
      if (wr_acc && idx == gpf_pkg::IDX_P2_FLAGS) begin
         p2f_nxt = (p2f_r & wbyte[4:0]) | ev2;
      end
   end

   // read data caught in the setup cycle, shown in the access cycle
   always_comb begin
      rd_nxt  = rd_r;
      err_nxt = err_r;
      if (psel && !penable) begin
         rd_nxt  = 8'h00;
         err_nxt = !is_mapped(paddr);
         case (idx)
            gpf_pkg::IDX_P0_FLAGS: rd_nxt = p0f_r;
            gpf_pkg::IDX_P1_FLAGS: rd_nxt = p1f_r;
            gpf_pkg::IDX_P2_FLAGS: rd_nxt = {3'b000, p2f_r};
            gpf_pkg::IDX_P1_COND:  rd_nxt = p1_cond_r;
            gpf_pkg::IDX_P2_COND:  rd_nxt = p2_cond_r;
            gpf_pkg::IDX_P0_MASK:  rd_nxt = mask0_r;
            gpf_pkg::IDX_P1_MASK:  rd_nxt = mask1_r;
            gpf_pkg::IDX_P2_MASK:  rd_nxt = {3'b000, mask2_r};
            gpf_pkg::IDX_EDGE_SEL: rd_nxt = {5'b00000, edge_r};
            default:               rd_nxt = 8'h00;
         endcase
         // misaligned or out-of-range addresses read zero
         if (err_nxt) begin
            rd_nxt = 8'h00;
         end
      end
   end

   // pad pulls from float selects and the per-port direction bits
   always_comb begin
      p0_pu_nxt = pull_on(p0_float_sel, p2_cond_r[gpf_pkg::P0_PULL_DIR_BIT], 1'b0);
      p0_pd_nxt = pull_on(p0_float_sel, p2_cond_r[gpf_pkg::P0_PULL_DIR_BIT], 1'b1);
      // pins 1 and 0 have no pull hardware at all
      p1_pu_nxt = pull_on(p1_cond_r, p2_cond_r[gpf_pkg::P1_PULL_DIR_BIT], 1'b0)
                  & 8'hFC;
      p1_pd_nxt = pull_on(p1_cond_r, p2_cond_r[gpf_pkg::P1_PULL_DIR_BIT], 1'b1)
                  & 8'hFC;
      p2_pu_nxt = 5'(pull_on({3'b111, p2_cond_r[4:0]},
                             p2_cond_r[gpf_pkg::P2_PULL_DIR_BIT], 1'b0));
      p2_pd_nxt = 5'(pull_on({3'b111, p2_cond_r[4:0]},
                             p2_cond_r[gpf_pkg::P2_PULL_DIR_BIT], 1'b1));
      // next masks too, so a mask write and the line move on the same edge
      irq_nxt   = |(p0f_nxt & mask0_nxt) || |(p1f_nxt & mask1_nxt) || |(p2f_nxt & mask2_nxt);
   end

   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p1_cond_r    <= gpf_pkg::RST_BYTE;
         p2_cond_r    <= gpf_pkg::RST_BYTE;
         edge_r       <= gpf_pkg::RST_EDGE;
         mask0_r      <= gpf_pkg::RST_BYTE;
         mask1_r      <= gpf_pkg::RST_BYTE;
         mask2_r      <= gpf_pkg::RST_P2;
         p0f_r        <= gpf_pkg::RST_BYTE;
         p1f_r        <= gpf_pkg::RST_BYTE;
         p2f_r        <= gpf_pkg::RST_P2;
         rd_r         <= gpf_pkg::RST_BYTE;
         err_r        <= 1'b0;
         p0_pull_up   <= gpf_pkg::RST_BYTE;
         p0_pull_down <= gpf_pkg::RST_BYTE;
         p1_pull_up   <= gpf_pkg::RST_BYTE;
         p1_pull_down <= gpf_pkg::RST_BYTE;
         p2_pull_up   <= gpf_pkg::RST_P2;
         p2_pull_down <= gpf_pkg::RST_P2;
         irq          <= 1'b0;
      end else begin
         p1_cond_r    <= p1_cond_nxt;
         p2_cond_r    <= p2_cond_nxt;
         edge_r       <= edge_nxt;
         mask0_r      <= mask0_nxt;
         mask1_r      <= mask1_nxt;
         mask2_r      <= mask2_nxt;
         p0f_r        <= p0f_nxt;
         p1f_r        <= p1f_nxt;
         p2f_r        <= p2f_nxt;
         rd_r         <= rd_nxt;
         err_r        <= err_nxt;
         p0_pull_up   <= p0_pu_nxt;
         p0_pull_down <= p0_pd_nxt;
         p1_pull_up   <= p1_pu_nxt;
         p1_pull_down <= p1_pd_nxt;
         p2_pull_up   <= p2_pu_nxt;
         p2_pull_down <= p2_pd_nxt;
         irq          <= irq_nxt;
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // floating port 1 pins never pulled
   property p_p1_float;
      ((p1_pull_up | p1_pull_down) & $past(p1_cond_r)) == 8'h00;
   endproperty
   a_p1_float: assert property (p_p1_float) else $error("floating p1 pin pulled");

   // lowest port 1 pins never pulled, bits held zero
   property p_p1_low;
      (p1_pull_up[1:0] == 2'b00) && (p1_pull_down[1:0] == 2'b00) && (p1_cond_r[1:0] == 2'b00);
   endproperty
   a_p1_low: assert property (p_p1_low) else $error("p1 low pins pulled");

   // port 2 direction steers the pull down pad of pulled pins
   property p_p2_dir;
      p2_pull_down == ($past(~p2_cond_r[4:0]) & {5{$past(p2_cond_r[7])}});
   endproperty
   a_p2_dir: assert property (p_p2_dir) else $error("p2 pull down wrong");

   // port 1 pull up follows direction bit one cycle later
   property p_p1_dir;
      presetn && !p2_cond_r[6] && (p1_cond_r[7:2] == 6'h00) |=> p1_pull_up == 8'hFC;
   endproperty
   a_p1_dir: assert property (p_p1_dir) else $error("p1 pull up wrong");

   // port 0 pull up from outside float select and direction
   property p_p0_dir;
      // pads still hold reset zeros on the first edge after release
      $past(presetn) |-> p0_pull_up == ($past(~p0_float_sel) & ~{8{$past(p2_cond_r[5])}});
   endproperty
   a_p0_dir: assert property (p_p0_dir) else $error("p0 pull up wrong");

   // port 2 float bits take the written value
   property p_p2_wr;
      wr_acc && idx == gpf_pkg::IDX_P2_COND |=> p2_cond_r == $past(wbyte);
   endproperty
   a_p2_wr: assert property (p_p2_wr) else $error("p2 cond write lost");

   // a port 1 edge event sets its flag even during a clear
   property p_p1_set;
      ev1 != 8'h00 |=> (p1f_r & $past(ev1)) == $past(ev1);
   endproperty
   a_p1_set: assert property (p_p1_set) else $error("p1 event lost");

   // a port 0 pin 0 event sets its flag
   property p_p0_set;
      ev0[0] |=> p0f_r[0];
   endproperty
   a_p0_set: assert property (p_p0_set) else $error("p0 event lost");

   // resume variant: bit 6 never set, resume sets bit 7
   property p_resume;
      HAS_BUS_RESUME && bus_resume_evt |=> p0f_r[7] && !p0f_r[6];
   endproperty
   a_resume: assert property (p_resume) else $error("resume flag wrong");

   // port 2 flag read shows zeros on top
   property p_p2_top;
      psel && !penable && idx == gpf_pkg::IDX_P2_FLAGS |=> prdata[7:5] == 3'b000;
   endproperty
   a_p2_top: assert property (p_p2_top) else $error("p2 top bits set");

   // rising edge on p1 pin 0 with rising select sets flag next edge
   property p_p1_rise;
      !edge_r[1] && $rose(p1_in[0]) && $past(u_e1.armed_r) |=> p1f_r[0];
   endproperty
   a_p1_rise: assert property (p_p1_rise) else $error("rising edge missed");

   // writing zero with no event clears, writing one keeps
   property p_p1_clr;
      wr_acc && idx == gpf_pkg::IDX_P1_FLAGS && ev1 == 8'h00
         |=> p1f_r == ($past(p1f_r) & $past(wbyte));
   endproperty
   a_p1_clr: assert property (p_p1_clr) else $error("p1 flag write wrong");

   // interrupt tracks unmasked flags
   property p_irq;
      irq == (|(p0f_r & mask0_r) || |(p1f_r & mask1_r) || |(p2f_r & mask2_r));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   // main scenarios
   c_p0_flag: cover property (ev0 != 8'h00 ##1 p0f_r != 8'h00);
   c_irq:     cover property ($rose(irq));
   c_clear:   cover property (wr_acc && idx == gpf_pkg::IDX_P1_FLAGS && p1f_r != 8'h00);
   c_err:     cover property (psel && penable && pslverr);
endmodule : gpf_top

//--- testbench/gpf_pin_model.sv
// partner model: pads and board circuitry behind the three ports
module gpf_pin_model (
   // clock
   input  wire logic        pclk,
   // what the board does to each pin, bits 20..16 port 2, 15..8 port 1, 7..0 port 0
   input  wire logic [20:0] drive,
   input  wire logic [20:0] level,
   // pull enables from the block
   input  wire logic [20:0] pull_up,
   input  wire logic [20:0] pull_down,
   // pin levels seen by the block
   output logic      [20:0] pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // driven pins follow the board, released pins follow the pull
   // an unpulled released pin flips every cycle, so a stale level never passes
   always_ff @(posedge pclk) begin
      for (int i = 0; i < 21; i++) begin
         if (drive[i]) begin
            pins[i] <= level[i];
         end else if (pull_up[i]) begin
            pins[i] <= 1'b1;
         end else if (pull_down[i]) begin
            pins[i] <= 1'b0;
         end else begin
            pins[i] <= ~pins[i];
         end
      end
   end
endmodule : gpf_pin_model

//--- testbench/tb.sv
// testbench: register access, pulls, pending flags and interrupt of the pin flag block
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // one row: conditioning writes, readback and pulls they give
   typedef struct packed {
      logic [7:0] c1, c2, f0, rd1, rd2, p0u, p0d, p1u, p1d;
      logic [4:0] p2u, p2d;
   } gpf_row_t;
   logic        pclk, presetn, psel, penable, pwrite, bus_resume_evt;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [7:0]  p0_float_sel;
   logic [20:0] drive, level;
   wire  logic  pready, pslverr, irq;
   wire  logic [31:0] prdata;
   wire  logic [20:0] pins, pu, pd;
   wire  logic [31:0] prdata_res;
   gpf_row_t    rows [4];
   int          miscompares, checked;
   logic [31:0] rdv, rdv_res;
   logic        errv;

   gpf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .p0_in(pins[7:0]), .p1_in(pins[15:8]),
      .p2_in(pins[20:16]), .p0_float_sel(p0_float_sel), .bus_resume_evt(bus_resume_evt),
      .p0_pull_up(pu[7:0]), .p0_pull_down(pd[7:0]), .p1_pull_up(pu[15:8]),
      .p1_pull_down(pd[15:8]), .p2_pull_up(pu[20:16]), .p2_pull_down(pd[20:16]), .irq(irq));
   gpf_pin_model pins_u (.pclk(pclk), .drive(drive), .level(level), .pull_up(pu),
      .pull_down(pd), .pins(pins));
   // resume variant beside the plain one, same bus and pins
   gpf_top #(.HAS_BUS_RESUME(1'b1)) dut_res_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(), .prdata(prdata_res), .pslverr(), .p0_in(pins[7:0]), .p1_in(pins[15:8]),
      .p2_in(pins[20:16]), .p0_float_sel(p0_float_sel), .bus_resume_evt(bus_resume_evt),
      .p0_pull_up(), .p0_pull_down(), .p1_pull_up(), .p1_pull_down(), .p2_pull_up(),
      .p2_pull_down(), .irq());

   // clock, 25 ns period
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // closing report, the only place the run ends
   task automatic print_verdict;
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      input logic [3:0] st);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h00_0000, wd};
      pstrb   <= st;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         $display("unexpected at %0t: no pready", $time);
         print_verdict();
      end
      rdv = prdata;
      rdv_res = prdata_res;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 4'hf);
   endtask : wr

   // read one register and compare the whole word and the error flag
   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00, 4'h0);
      `CHK({errv, rdv}, {1'b0, 24'h00_0000, e})
   endtask : rdc

   // all three flag registers hold either every flag or none
   task automatic flags(input logic all);
      rdc(gpf_pkg::IDX_P0_FLAGS, all ? 8'hff : 8'h00);
      rdc(gpf_pkg::IDX_P1_FLAGS, all ? 8'hff : 8'h00);
      rdc(gpf_pkg::IDX_P2_FLAGS, all ? 8'h1f : 8'h00);
   endtask : flags

   task automatic clear_all;
      wr(gpf_pkg::IDX_P0_FLAGS, 8'h00);
      wr(gpf_pkg::IDX_P1_FLAGS, 8'h00);
      wr(gpf_pkg::IDX_P2_FLAGS, 8'h00);
   endtask : clear_all

   // main sequence
   initial begin
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
      pstrb = 4'h0; p0_float_sel = 8'h00; bus_resume_evt = 1'b0; presetn = 1'b0;
      drive = {21{1'b1}}; level = '0; miscompares = 0; checked = 0;
      rows[0] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hfc, 8'h00, 5'h1f, 5'h00};
      rows[1] = '{8'hff, 8'hff, 8'h0f, 8'hfc, 8'hff, 8'h00, 8'hf0, 8'h00, 8'h00, 5'h00, 5'h00};
      rows[2] = '{8'ha8, 8'h6a, 8'h33, 8'ha8, 8'h6a, 8'h00, 8'hcc, 8'h00, 8'h54, 5'h15, 5'h00};
      rows[3] = '{8'h57, 8'h95, 8'hc3, 8'h54, 8'h95, 8'h3c, 8'h00, 8'ha8, 8'h00, 5'h00, 5'h0a};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then an unmapped place
      flags(1'b0);
      rdc(gpf_pkg::IDX_P1_COND, 8'h00);
      rdc(gpf_pkg::IDX_P2_COND, 8'h00);
      apb(1'b0, 8'h00, 8'h00, 4'h0);
      `CHK({errv, rdv}, {1'b1, 32'h0000_0000})
      // conditioning rows, board lets go of every pin
      drive <= '0;
      foreach (rows[i]) begin
         p0_float_sel <= rows[i].f0;
         wr(gpf_pkg::IDX_P1_COND, rows[i].c1);
         wr(gpf_pkg::IDX_P2_COND, rows[i].c2);
         rdc(gpf_pkg::IDX_P1_COND, rows[i].rd1);
         rdc(gpf_pkg::IDX_P2_COND, rows[i].rd2);
         `CHK({pu[7:0], pd[7:0]}, {rows[i].p0u, rows[i].p0d})
         `CHK({pu[15:8], pd[15:8]}, {rows[i].p1u, rows[i].p1d})
         `CHK({pu[20:16], pd[20:16]}, {rows[i].p2u, rows[i].p2d})
         `CHK(pins[7:0] & (pu[7:0] | pd[7:0]), pu[7:0])
      end
      drive <= {21{1'b1}};
      level <= '0;
      // rising then falling choice: only the chosen transition flags
      for (int e = 0; e < 2; e++) begin
         wr(gpf_pkg::IDX_EDGE_SEL, e ? 8'h07 : 8'h00);
         rdc(gpf_pkg::IDX_EDGE_SEL, e ? 8'h07 : 8'h00);
         level <= {21{e[0]}};
         repeat (3) @(posedge pclk);
         clear_all();
         flags(1'b0);
         level <= {21{~e[0]}};
         repeat (3) @(posedge pclk);
         flags(1'b1);
         clear_all();
         level <= {21{e[0]}};
         repeat (3) @(posedge pclk);
         flags(1'b0);
      end
      // falling choice still set: all flags rise together
      level <= '0;
      repeat (3) @(posedge pclk);
      wr(gpf_pkg::IDX_P1_FLAGS, 8'hff);
      rdc(gpf_pkg::IDX_P1_FLAGS, 8'hff);
      apb(1'b1, gpf_pkg::IDX_P1_FLAGS, 8'h00, 4'h0);
      rdc(gpf_pkg::IDX_P1_FLAGS, 8'hff);
      `CHK(irq, 1'b0)
      wr(gpf_pkg::IDX_P1_MASK, 8'h01);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b1)
      wr(gpf_pkg::IDX_P1_FLAGS, 8'hfe);
      rdc(gpf_pkg::IDX_P1_FLAGS, 8'hfe);
      `CHK(irq, 1'b0)
      // resume pulse has no effect on the plain variant
      wr(gpf_pkg::IDX_P0_FLAGS, 8'h00);
      @(posedge pclk);
      bus_resume_evt <= 1'b1;
      @(posedge pclk);
      bus_resume_evt <= 1'b0;
      rdc(gpf_pkg::IDX_P0_FLAGS, 8'h00);
      `CHK(rdv_res, 32'h0000_0080)
      // reset in mid-run drops the port 1 flags, the interrupt stays low
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(gpf_pkg::IDX_P1_FLAGS, 8'h00);
      `CHK(irq, 1'b0)
      print_verdict();
   end
endmodule : tb
